// ### src/csr_cpu_status.sv
// CPU status and reset flag register with Wishbone slave and interrupt gate.
// Assumes core events arrive as one-cycle pulses on the core clock.
`timescale 1ns/10ps
`default_nettype none
// Function
// - Stack free flag clears on any cycle where the stack pointer input equals Fh and no device reset is active.
// - After clearing, stack free flag returns to one only on device reset or power-on reset.
// - Global interrupt mask bit 4 high blocks all sources at CPU_IRQ_OUT (not IRQ_OUT); low allows unmasked.
// - With interrupts enabled, only individually enabled sources raise an interrupt.
// - Watchdog expiry flag set by power-up, watchdog clear, sleep; cleared by timeout.
// - Power down flag set by power-up or watchdog clear; cleared by sleep.
// - Power-on reset clears bit 1; software writes it back to one.
// - With brownout detect enabled, brownout reset clears bit 0; software sets it.
// - Writes to watchdog expiry, power down and stack free flags are ignored.
// - Upper two register bits are unimplemented and read as zero.
// - After power-on reset bits 5,4,3,2,0 read one and bit 1 zero.
// - In RC mode the clock output pin carries oscillator divided by four.
// - Brownout below trip point holds device in reset until supply recovers.
module csr_cpu_status
	import csr_pkg::*;
(
	input  wire logic             CLK_SYS_IN,
	input  wire logic             RESET_N_IN,
	input  wire logic             CE_IN,
	// Wishbone slave
	input  wire logic             WB_CYC_IN,
	input  wire logic             WB_STB_IN,
	input  wire logic             WB_WE_IN,
	input  wire logic [7:0]       WB_ADR_IN,
	input  wire logic [3:0]       WB_SEL_IN,
	input  wire logic [31:0]      WB_DAT_IN,
	output logic      [31:0]      WB_DAT_OUT,
	output logic                  WB_ACK_OUT,
	// Core events and levels
	input  wire logic [3:0]       STACK_PTR_IN,
	input  wire logic             WATCHDOG_CLEAR_INSTR_IN,
	input  wire logic             SLEEP_INSTR_IN,
	input  wire logic             WATCHDOG_TIMEOUT_IN,
	input  wire logic             DEVICE_RESET_IN,
	input  wire logic             BROWNOUT_LOW_IN,
	input  wire logic             BROWNOUT_DETECT_FUSE_IN,
	input  wire logic             RC_MODE_IN,
	input  wire logic [SRC_W-1:0] IRQ_SOURCES_IN,
	// Outputs
	output logic                  CPU_IRQ_OUT,
	output logic                  BROWNOUT_RESET_OUT,
	output logic                  CLOCK_OUT,
	output logic                  IRQ_OUT
);
	logic [7:0]       status_q;
	logic [7:0]       status_d;
	logic [SRC_W-1:0] irq_en_q;
	logic [SRC_W-1:0] irq_en_d;
	logic             ack_q;
	logic             ack_d;
	logic [31:0]      dat_q;
	logic [31:0]      dat_d;
	logic             cpu_irq_q;
	logic             cpu_irq_d;
	logic             bor_hold_q;
	logic             bor_hold_d;
	logic [1:0]       div_q;
	logic [1:0]       div_d;
	logic             clk_out_q;
	logic             clk_out_d;

	logic             bus_req;
	logic             bus_wr;
	logic             wr_lane0;
	logic [5:0]       reg_idx;
	logic             bor_trip;
	logic             dev_reset;
	logic [EVT_W-1:0] evt_pulse;

	csr_evt_if evt_bus ();

	// ==========================================================
	// Bus decode
	assign reg_idx  = WB_ADR_IN[7:2];
	assign bus_req  = WB_CYC_IN & WB_STB_IN & ~ack_q;
	assign bus_wr   = bus_req & WB_WE_IN;
	assign wr_lane0 = bus_wr & WB_SEL_IN[0];

	// Brownout only counts when the fuse enables detection
	assign bor_trip  = BROWNOUT_LOW_IN & BROWNOUT_DETECT_FUSE_IN;
	assign dev_reset = DEVICE_RESET_IN | bor_trip;

	// ==========================================================
	// Status register next value
	always_comb begin
		status_d = status_q;
		if (wr_lane0 && reg_idx == IDX_STATUS) begin
			// Only the writable bits follow the bus
			status_d = (status_q & ~STATUS_WMSK) | (WB_DAT_IN[7:0] & STATUS_WMSK);
		end
		if (WATCHDOG_CLEAR_INSTR_IN) begin
			status_d[BIT_TO] = 1'b1;
			status_d[BIT_PD] = 1'b1;
		end
		if (SLEEP_INSTR_IN) begin
			status_d[BIT_TO] = 1'b1;
			status_d[BIT_PD] = 1'b0;
		end
		// Timeout applied last so it is never masked by a clear
		if (WATCHDOG_TIMEOUT_IN) begin
			status_d[BIT_TO] = 1'b0;
		end
		if (STACK_PTR_IN == SP_FULL) begin
			status_d[BIT_STK] = 1'b0;
		end
		if (dev_reset) begin
			// Only a reset restores stack free
			status_d[BIT_STK]   = 1'b1;
			status_d[BIT_GLINT] = 1'b1;
		end
		if (bor_trip) begin
			status_d[BIT_BOR] = 1'b0;
		end
		status_d = status_d & STATUS_IMPL;
	end

	// ==========================================================
	// Interrupt gate, brownout hold, clock divider
	always_comb begin
		irq_en_d = irq_en_q;
		if (wr_lane0 && reg_idx == IDX_IRQ_EN) begin
			irq_en_d = WB_DAT_IN[SRC_W-1:0];
		end
		// Global mask wins over every enabled source
		cpu_irq_d = ~status_q[BIT_GLINT] & (|(IRQ_SOURCES_IN & irq_en_q));
		bor_hold_d = bor_trip;
		div_d      = div_q + 2'h1;
		clk_out_d  = RC_MODE_IN & div_q[1];
	end

	// ==========================================================
	// Event pulses toward the sticky bank
	always_comb begin
		evt_pulse          = '0;
		evt_pulse[EVT_STK] = status_q[BIT_STK] & ~status_d[BIT_STK];
		evt_pulse[EVT_WDT] = WATCHDOG_TIMEOUT_IN;
		evt_pulse[EVT_BOR] = bor_trip & ~bor_hold_q;
		evt_pulse[EVT_SLP] = SLEEP_INSTR_IN;
	end

	assign evt_bus.evt     = evt_pulse;
	assign evt_bus.wr_data = WB_DAT_IN[EVT_W-1:0];
	assign evt_bus.clr_we  = wr_lane0 && reg_idx == IDX_EVT_STAT;
	assign evt_bus.mask_we = wr_lane0 && reg_idx == IDX_EVT_MASK;

	// ==========================================================
	// Bus answer; unmapped reads return zero, writes are dropped
	always_comb begin
		ack_d = bus_req;
		dat_d = dat_q;
		if (bus_req && !WB_WE_IN) begin
			case (reg_idx)
				IDX_STATUS:   dat_d = {24'h000000, status_q & STATUS_IMPL};
				IDX_IRQ_EN:   dat_d = {24'h000000, irq_en_q};
				IDX_IRQ_SRC:  dat_d = {24'h000000, IRQ_SOURCES_IN & irq_en_q};
				IDX_EVT_STAT: dat_d = {28'h0000000, evt_bus.status};
				IDX_EVT_MASK: dat_d = {28'h0000000, evt_bus.mask};
				default:      dat_d = 32'h00000000;
			endcase
		end
	end

	// ==========================================================
	// Registers; this reset is the power-on reset
	always_ff @(posedge CLK_SYS_IN) begin
		if (!RESET_N_IN) begin
			status_q   <= STATUS_RST;
			irq_en_q   <= IRQ_EN_RST;
			ack_q      <= 1'b0;
			dat_q      <= 32'h00000000;
			cpu_irq_q  <= 1'b0;
			bor_hold_q <= 1'b0;
			div_q      <= CLKDIV_RST;
			clk_out_q  <= 1'b0;
		end else if (CE_IN) begin
			status_q   <= status_d;
			irq_en_q   <= irq_en_d;
			ack_q      <= ack_d;
			dat_q      <= dat_d;
			cpu_irq_q  <= cpu_irq_d;
			bor_hold_q <= bor_hold_d;
			div_q      <= div_d;
			clk_out_q  <= clk_out_d;
		end
	end

	csr_evt_bank u_evt_bank (
		.clk_in   (CLK_SYS_IN),
		.rst_n_in (RESET_N_IN),
		.ce_in    (CE_IN),
		.ev       (evt_bus.bank)
	);

	assign WB_ACK_OUT         = ack_q;
	assign WB_DAT_OUT         = dat_q;
	assign CPU_IRQ_OUT        = cpu_irq_q;
	assign BROWNOUT_RESET_OUT = bor_hold_q;
	assign CLOCK_OUT          = clk_out_q;
	assign IRQ_OUT            = evt_bus.irq;
endmodule : csr_cpu_status
`default_nettype wire

// ### src/csr_pkg.sv
// Constants for the CPU status and reset flag block.
// Assumes a single 100 MHz core clock and a 32-bit classic Wishbone slave port.
package csr_pkg;

	// ==========================================================
	// Register indices (byte address is four times the index)
	localparam logic [5:0] IDX_IRQ_EN   = 6'h00;
	localparam logic [5:0] IDX_IRQ_SRC  = 6'h01;
	localparam logic [5:0] IDX_EVT_STAT = 6'h02;
	localparam logic [5:0] IDX_EVT_MASK = 6'h03;
	localparam logic [5:0] IDX_STATUS   = 6'h06;

	// ==========================================================
	// Status register fields
	localparam int BIT_BOR   = 0;
	localparam int BIT_POR   = 1;
	localparam int BIT_PD    = 2;
	localparam int BIT_TO    = 3;
	localparam int BIT_GLINT = 4;
	localparam int BIT_STK   = 5;
	localparam logic [7:0] STATUS_RST  = 8'h3D;
	localparam logic [7:0] STATUS_WMSK = 8'h13;
	localparam logic [7:0] STATUS_IMPL = 8'h3F;

	// ==========================================================
	// Stack, sources, events, clock divider
	localparam logic [3:0] SP_FULL   = 4'hF;
	localparam int         SRC_W     = 8;
	localparam logic [7:0] IRQ_EN_RST = 8'h00;
	localparam int         EVT_W     = 4;
	localparam int         EVT_STK   = 0;
	localparam int         EVT_WDT   = 1;
	localparam int         EVT_BOR   = 2;
	localparam int         EVT_SLP   = 3;
	localparam logic [EVT_W-1:0] EVT_RST = 4'h0;
	localparam logic [1:0] CLKDIV_RST = 2'h0;

endpackage : csr_pkg

// ### src/csr_evt_if.sv
// Carrier between the status block and its sticky event bank.
// Assumes both ends share the core clock.
`timescale 1ns/10ps
`default_nettype none
interface csr_evt_if;
	import csr_pkg::*;
	logic [EVT_W-1:0] evt;
	logic [EVT_W-1:0] wr_data;
	logic             clr_we;
	logic             mask_we;
	logic [EVT_W-1:0] status;
	logic [EVT_W-1:0] mask;
	logic             irq;

	modport ctl  (output evt, wr_data, clr_we, mask_we, input status, mask, irq);
	modport bank (input evt, wr_data, clr_we, mask_we, output status, mask, irq);
endinterface : csr_evt_if
`default_nettype wire

// ### src/csr_evt_bank.sv
// Sticky event status with write-one-to-clear, mask and level interrupt.
// Assumes event pulses and write strobes are synchronous to the clock.
`timescale 1ns/10ps
`default_nettype none
module csr_evt_bank
	import csr_pkg::*;
(
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	input  wire logic ce_in,
	csr_evt_if.bank   ev
);
	logic [EVT_W-1:0] status_q;
	logic [EVT_W-1:0] status_d;
	logic [EVT_W-1:0] mask_q;
	logic [EVT_W-1:0] mask_d;
	logic             irq_q;
	logic             irq_d;

	// ==========================================================
	// Next state
	always_comb begin
		status_d = status_q;
		mask_d   = mask_q;
		if (ev.clr_we) begin
			status_d = status_d & ~ev.wr_data;
		end
		// New event beats a clear in the same cycle
		status_d = status_d | ev.evt;
		if (ev.mask_we) begin
			mask_d = ev.wr_data;
		end
		irq_d = |(status_d & mask_d);
	end

	// ==========================================================
	// Registers
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			status_q <= EVT_RST;
			mask_q   <= EVT_RST;
			irq_q    <= 1'b0;
		end else if (ce_in) begin
			status_q <= status_d;
			mask_q   <= mask_d;
			irq_q    <= irq_d;
		end
	end

	assign ev.status = status_q;
	assign ev.mask   = mask_q;
	assign ev.irq    = irq_q;
endmodule : csr_evt_bank
`default_nettype wire

// ### verif/csr_cpu_status_monitor.sv
// Port checker for the CPU status and reset flag block.
// Assumes CE_IN high while pins are exercised and binding onto csr_cpu_status.
`timescale 1ns/10ps
`default_nettype none
module csr_mon
	import csr_pkg::*;
(
	input wire logic             CLK_SYS_IN,
	input wire logic             RESET_N_IN,
	input wire logic             CE_IN,
	input wire logic             WB_CYC_IN,
	input wire logic             WB_STB_IN,
	input wire logic             WB_WE_IN,
	input wire logic [7:0]       WB_ADR_IN,
	input wire logic [31:0]      WB_DAT_OUT,
	input wire logic             WB_ACK_OUT,
	input wire logic             BROWNOUT_LOW_IN,
	input wire logic             BROWNOUT_DETECT_FUSE_IN,
	input wire logic             RC_MODE_IN,
	input wire logic [SRC_W-1:0] IRQ_SOURCES_IN,
	input wire logic             CPU_IRQ_OUT,
	input wire logic             BROWNOUT_RESET_OUT,
	input wire logic             CLOCK_OUT
);
	default clocking @(posedge CLK_SYS_IN); endclocking
	default disable iff (!RESET_N_IN);
	// ==========================================================
	// Bus answer
	// A frozen clock enable also freezes the answer
	property p_ack_due; CE_IN && WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT; endproperty
	a_ack_due: assert property (p_ack_due) else $error("request not acked");
	property p_ack_only; !(WB_CYC_IN && WB_STB_IN) |=> !WB_ACK_OUT; endproperty
	a_ack_only: assert property (p_ack_only) else $error("ack without request");
	property p_ack_pulse; WB_ACK_OUT |=> !WB_ACK_OUT; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	property p_hi_zero;
		WB_ACK_OUT && !$past(WB_WE_IN) && $past(WB_ADR_IN[7:2]) == IDX_STATUS |-> WB_DAT_OUT[31:6] == 26'h0;
	endproperty
	a_hi_zero: assert property (p_hi_zero) else $error("status upper bits set");
	// ==========================================================
	// Pins
	property p_no_src; IRQ_SOURCES_IN == 8'h00 |=> !CPU_IRQ_OUT; endproperty
	a_no_src: assert property (p_no_src) else $error("irq with no source");
	property p_bor_on; BROWNOUT_LOW_IN && BROWNOUT_DETECT_FUSE_IN |=> BROWNOUT_RESET_OUT; endproperty
	a_bor_on: assert property (p_bor_on) else $error("brownout reset missing");
	property p_bor_end; $fell(BROWNOUT_LOW_IN) |=> !BROWNOUT_RESET_OUT; endproperty
	a_bor_end: assert property (p_bor_end) else $error("brownout reset held");
	property p_bor_off; !BROWNOUT_DETECT_FUSE_IN |=> !BROWNOUT_RESET_OUT; endproperty
	a_bor_off: assert property (p_bor_off) else $error("brownout reset while disabled");
	property p_clk_off; !RC_MODE_IN |=> !CLOCK_OUT; endproperty
	a_clk_off: assert property (p_clk_off) else $error("clock out outside rc mode");
	// Two high, two low: always differs from two cycles back
	property p_clk_div; RC_MODE_IN [*5] |-> CLOCK_OUT != $past(CLOCK_OUT, 2); endproperty
	a_clk_div: assert property (p_clk_div) else $error("clock out not divided by four");
endmodule : csr_mon
bind csr_cpu_status csr_mon csr_mon_i (.*);
`default_nettype wire

// ### verif/tb_csr_cpu_status.sv
// Self-checking bench for the CPU status block over Wishbone.
// Assumes csr_pkg, the design and its checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb_csr_cpu_status;
	import csr_pkg::*;
	logic        clk    = 1'b0;
	logic        rst_n  = 1'b0;
	logic        cyc    = 1'b0;
	logic        we     = 1'b0;
	logic [7:0]  adr    = 8'h00;
	logic [31:0] wdat   = 32'h0;
	logic [31:0] rdat, got;
	logic        ack, cpu_irq, bo_rst, clk_out, irq;
	logic [3:0]  sp     = 4'h0;
	logic [3:0]  ev     = 4'h0;
	logic        bo_low = 1'b0;
	logic        fuse   = 1'b0;
	logic        rc     = 1'b0;
	logic        ce     = 1'b1;
	logic [7:0]  cw     = 8'h00;
	logic [7:0]  src    = 8'h03;
	int          failures = 0;
	int          checked  = 0;
	int          cycles   = 0;
	always #5 clk = ~clk;
	csr_cpu_status csr_cpu_status_i (.CLK_SYS_IN(clk), .RESET_N_IN(rst_n), .CE_IN(ce),
		.WB_CYC_IN(cyc), .WB_STB_IN(cyc), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(4'hF),
		.WB_DAT_IN(wdat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .STACK_PTR_IN(sp),
		.WATCHDOG_CLEAR_INSTR_IN(ev[0]), .SLEEP_INSTR_IN(ev[1]), .WATCHDOG_TIMEOUT_IN(ev[2]),
		.DEVICE_RESET_IN(ev[3]), .BROWNOUT_LOW_IN(bo_low), .BROWNOUT_DETECT_FUSE_IN(fuse),
		.RC_MODE_IN(rc), .IRQ_SOURCES_IN(src), .CPU_IRQ_OUT(cpu_irq), .BROWNOUT_RESET_OUT(bo_rst),
		.CLOCK_OUT(clk_out), .IRQ_OUT(irq));
	// ==========================================================
	// Tasks
	task automatic end_of_test();
		if (failures == 0 && checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			failures++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	// Holds the request until ack is sampled; no fixed latency assumed
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h000000, d};
		do @(posedge clk); while (ack !== 1'b1);
		got = rdat;
		cyc <= 1'b0;
	endtask : wb
	task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		wb(1'b0, a, 8'h00);
		chk({got[31:8], got[7:0] & m}, {24'h000000, e});
	endtask : rd
	// Event pulse of one cycle; zero just waits two edges
	task automatic pe(input logic [3:0] v);
		@(posedge clk);
		ev <= v;
		@(posedge clk);
		ev <= 4'h0;
	endtask : pe
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			end_of_test();
		end
	end
	// ==========================================================
	// Sequence
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		rd(8'h18, 8'hFF, 8'h3D);
		wb(1'b1, 8'h18, 8'hFF);
		rd(8'h18, 8'hFF, 8'h3F);
		wb(1'b1, 8'h18, 8'h00);
		rd(8'h18, 8'hFF, 8'h2C);
		pe(4'h2);
		rd(8'h18, 8'hFF, 8'h28);
		pe(4'h4);
		rd(8'h18, 8'hFF, 8'h20);
		pe(4'h1);
		rd(8'h18, 8'hFF, 8'h2C);
		sp <= 4'hF;
		pe(4'h0);
		sp <= 4'h0;
		rd(8'h18, 8'hFF, 8'h0C);
		wb(1'b1, 8'h18, 8'h20);
		rd(8'h18, 8'hFF, 8'h0C);
		pe(4'h8);
		rd(8'h18, 8'h30, 8'h30);
		wb(1'b1, 8'h00, 8'h01);
		rd(8'h04, 8'hFF, 8'h01);
		chk({31'h00000000, cpu_irq}, 32'h00000000);
		wb(1'b1, 8'h18, 8'h03);
		@(posedge clk);
		chk({31'h00000000, cpu_irq}, 32'h00000001);
		// Enabled but silent sources raise nothing
		src <= 8'h00;
		repeat (2) @(posedge clk);
		chk({31'h00000000, cpu_irq}, 32'h00000000);
		src <= 8'h03;
		fuse <= 1'b1;
		bo_low <= 1'b1;
		pe(4'h0);
		chk({31'h00000000, bo_rst}, 32'h00000001);
		bo_low <= 1'b0;
		pe(4'h0);
		chk({31'h00000000, bo_rst}, 32'h00000000);
		rd(8'h18, 8'h21, 8'h20);
		wb(1'b1, 8'h18, 8'h01);
		rd(8'h18, 8'h01, 8'h01);
		// Sleep while the clock enable is low must be lost
		ce <= 1'b0;
		pe(4'h2);
		ce <= 1'b1;
		rd(8'h18, 8'h0C, 8'h0C);
		// Sticky events, mask and level interrupt
		rd(8'h08, 8'hFF, 8'h0F);
		wb(1'b1, 8'h08, 8'h0F);
		rd(8'h08, 8'hFF, 8'h00);
		wb(1'b1, 8'h0C, 8'h08);
		pe(4'h2);
		@(posedge clk);
		chk({31'h00000000, irq}, 32'h00000001);
		wb(1'b1, 8'h0C, 8'h00);
		@(posedge clk);
		chk({31'h00000000, irq}, 32'h00000000);
		wb(1'b1, 8'h40, 8'hFF);
		rd(8'h40, 8'hFF, 8'h00);
		fuse <= 1'b0;
		rc <= 1'b1;
		repeat (4) @(posedge clk);
		// Divide by four: every sample differs from the one two edges back
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			cw[i] = clk_out;
		end
		chk({26'h0000000, cw[7:2] ^ cw[5:0]}, 32'h0000003F);
		rc <= 1'b0;
		pe(4'h0);
		chk({31'h00000000, clk_out}, 32'h00000000);
		// Second power-on reset after software set the power-on bit
		wb(1'b1, 8'h18, 8'hFF);
		rd(8'h18, 8'h02, 8'h02);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rd(8'h18, 8'hFF, 8'h3D);
		end_of_test();
	end
endmodule : tb_csr_cpu_status
`default_nettype wire
